//--- src/mce_top.sv
/*
  Monitor calibration engine: holds the configuration and coefficient
  bytes, formats or corrects each converter sample and keeps the results.
  Assumes samples arrive from logic on the same clock, one per strobe.
*/
`timescale 1ns/1ps
module mce_top
  import mce_pkg::*;
(
  input  wire logic        clk,              // 50 MHz clock
  input  wire logic        reset_n,          // Async reset, active low
  input  wire logic        mem_wr_en,        // Byte write strobe
  input  wire logic [7:0]  mem_addr,         // Byte address
  input  wire logic [7:0]  mem_wdata,        // Byte write data
  output logic      [7:0]  mem_rdata,        // Registered read data
  input  wire logic        sample_valid,     // Converter sample strobe
  input  wire logic [2:0]  sample_chan,      // Channel of the sample
  input  wire logic [11:0] sample_code,      // Raw converter code
  output logic [15:0] temperature_result_pair, // Temperature result
  output logic [15:0] supply_result_pair,    // Supply voltage result
  output logic [7:0]  bias_result_high,      // Bias result high byte
  output logic [7:0]  bias_result_low,       // Bias result low byte
  output logic [7:0]  tx_power_result_high,  // TX power high byte
  output logic [7:0]  tx_power_result_low,   // TX power low byte
  output logic [7:0]  rx_power_result_high,  // RX power high byte
  output logic [7:0]  rx_power_result_low,   // RX power low byte
  output logic        internal_cal_select    // Internal mode active
);

  logic        rst_sync1_ff;
  logic        rst_sync2_ff;
  logic [7:0]  mem_ff [MEM_DEPTH];
  logic [7:0]  rdata_ff;
  logic [15:0] temp_ff;
  logic [15:0] supply_ff;
  logic [15:0] bias_ff;
  logic [15:0] tx_ff;
  logic [15:0] rx_ff;
  logic [15:0] fmt_value;
  logic [7:0]  slope_addr;
  logic [15:0] slope_word;
  logic [15:0] offset_word;
  logic [2:0]  rx_index;
  logic [1:0]  delim_sel;
  logic        int_cal;
  logic        temp_chan;
  logic [15:0] cal_value;
  logic [15:0] nxt_result;

  // Reset release is synchronised; assertion stays asynchronous.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  // Two-byte coefficient fetch, high byte first in memory.
  function automatic logic [15:0] rd16(input logic [7:0] addr);
    logic [7:0] next_addr;
    next_addr = addr + 8'h01;
    rd16 = {mem_ff[addr], mem_ff[next_addr]};
  endfunction

  // Raw code placed in the stored result format of its channel.
  function automatic logic [15:0] format_raw(input logic [2:0]  chan,
                                             input logic [11:0] code);
    case (chan)
      CH_TEMP:   format_raw = {{7{code[8]}}, code[8:0]} << TEMP_OFFSET_SHIFT;
      CH_SUPPLY: format_raw = {code[7:0], 8'h00};
      CH_BIAS:   format_raw = {code[7:0], 8'h00};
      CH_TX:     format_raw = {code[7:0], 8'h00};
      CH_RX:     format_raw = {code, 4'h0};
      default:   format_raw = 16'h0000;
    endcase
  endfunction

  assign int_cal   = mem_ff[CFG_THREE_ADDR][INT_CAL_BIT];
  assign delim_sel = mem_ff[CFG_SIX_ADDR][DELIM_SEL_LSB +: 2];
  assign temp_chan = (sample_chan == CH_TEMP);
  assign fmt_value = format_raw(sample_chan, sample_code);

  // Interval index is the count of delimiters not above the code.
  always_comb begin
    logic [15:0] delim;
    logic [7:0]  daddr;
    delim    = 16'h0000;
    daddr    = 8'h00;
    rx_index = 3'h0;
    for (int i = 0; i < DELIM_COUNT; i++) begin
      daddr = DELIM_BASE_ADDR + 8'(2 * i);
      if (delim_sel == DELIM_PROGRAMMED) begin
        delim = rd16(daddr);
      end else begin
        delim = FIXED_DELIM[i];
      end
      if (fmt_value >= delim) begin
        rx_index = rx_index + 3'h1;
      end
    end
  end

  always_comb begin
    case (sample_chan)
      CH_SUPPLY: slope_addr = SUPPLY_SLOPE_ADDR;
      CH_BIAS:   slope_addr = BIAS_SLOPE_ADDR;
      CH_TX:     slope_addr = TX_SLOPE_ADDR;
      CH_RX:     slope_addr = RX_SLOPE0_ADDR +
                              8'(rx_index * RX_SET_STRIDE);
      default:   slope_addr = SUPPLY_SLOPE_ADDR;
    endcase
  end

  assign slope_word  = rd16(slope_addr);
  assign offset_word = rd16(slope_addr + OFFSET_DISTANCE);

  mce_cal_math u_math (
    .sample_fmt  (fmt_value),
    .slope       (slope_word),
    .offset      (offset_word),
    .temp_mode   (temp_chan),
    .temp_offset (mem_ff[TEMP_OFFSET_ADDR][5:0]),
    .cal_value   (cal_value)
  );

  // Temperature always takes its offset; others only when internal.
  always_comb begin
    if (temp_chan || int_cal) begin
      nxt_result = cal_value;
    end else begin
      nxt_result = fmt_value;
    end
  end

  // Configuration and coefficient bytes.
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_ff[i] <= MEM_RESET_VALUE;
      end
    end else if (mem_wr_en) begin
      mem_ff[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      rdata_ff <= MEM_RESET_VALUE;
    end else begin
      rdata_ff <= mem_ff[mem_addr];
    end
  end

  // A result word loads only on a strobe for its own channel.
  function automatic logic take_chan(input logic [2:0] chan);
    take_chan = sample_valid && (sample_chan == chan);
  endfunction

  // Result registers, one word per channel; codes 5 to 7 load nothing.
  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      temp_ff <= RESULT_RESET;
    end else if (take_chan(CH_TEMP)) begin
      temp_ff <= nxt_result;
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      supply_ff <= RESULT_RESET;
    end else if (take_chan(CH_SUPPLY)) begin
      supply_ff <= nxt_result;
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      bias_ff <= RESULT_RESET;
    end else if (take_chan(CH_BIAS)) begin
      bias_ff <= nxt_result;
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      tx_ff <= RESULT_RESET;
    end else if (take_chan(CH_TX)) begin
      tx_ff <= nxt_result;
    end
  end

  always_ff @(posedge clk or negedge rst_sync2_ff) begin
    if (!rst_sync2_ff) begin
      rx_ff <= RESULT_RESET;
    end else if (take_chan(CH_RX)) begin
      rx_ff <= nxt_result;
    end
  end

  assign mem_rdata               = rdata_ff;
  assign temperature_result_pair = temp_ff;
  assign supply_result_pair      = supply_ff;
  assign bias_result_high        = bias_ff[15:8];
  assign bias_result_low         = bias_ff[7:0];
  assign tx_power_result_high    = tx_ff[15:8];
  assign tx_power_result_low     = tx_ff[7:0];
  assign rx_power_result_high    = rx_ff[15:8];
  assign rx_power_result_low     = rx_ff[7:0];
  assign internal_cal_select     = int_cal;

endmodule

//--- src/mce_pkg.sv
/*
  Constants for the monitor calibration engine: configuration-memory
  offsets, field positions, channel codes and reset values.
  Assumes a single 50 MHz clock domain and byte-wide configuration memory.
*/
package mce_pkg;

  localparam int          MEM_DEPTH         = 256;
  localparam logic [7:0]  CFG_THREE_ADDR    = 8'h03;
  localparam logic [7:0]  CFG_SIX_ADDR      = 8'h06;
  localparam int          INT_CAL_BIT       = 0;
  localparam int          DELIM_SEL_LSB     = 5;
  localparam logic [1:0]  DELIM_PROGRAMMED  = 2'h1;
  localparam logic [7:0]  TEMP_OFFSET_ADDR  = 8'h4a;
  localparam logic [7:0]  SUPPLY_SLOPE_ADDR = 8'h4c;
  localparam logic [7:0]  BIAS_SLOPE_ADDR   = 8'h50;
  localparam logic [7:0]  TX_SLOPE_ADDR     = 8'h54;
  localparam logic [7:0]  RX_SLOPE0_ADDR    = 8'h28;
  localparam logic [7:0]  RX_SET_STRIDE     = 8'h04;
  localparam logic [7:0]  OFFSET_DISTANCE   = 8'h02;
  localparam logic [7:0]  DELIM_BASE_ADDR   = 8'hd0;
  localparam int          DELIM_COUNT       = 7;
  localparam logic [7:0]  MEM_RESET_VALUE   = 8'h00;
  localparam logic [15:0] RESULT_RESET      = 16'h0000;
  localparam int          TEMP_OFFSET_SHIFT = 7;
  localparam int          FRAC_BITS         = 8;

  // Built-in RX interval boundaries on the left-justified 16-bit code.
  localparam logic [15:0] FIXED_DELIM [DELIM_COUNT] = '{
    16'h2000, 16'h4000, 16'h6000, 16'h8000, 16'ha000, 16'hc000, 16'he000
  };

  typedef enum logic [2:0] {
    CH_TEMP   = 3'b000,
    CH_SUPPLY = 3'b001,
    CH_BIAS   = 3'b010,
    CH_TX     = 3'b011,
    CH_RX     = 3'b100
  } mce_chan_t;

endpackage

//--- src/mce_cal_math.sv
/*
  Combinational slope and offset arithmetic with rounding and clamping.
  Assumes the caller presents a formatted 16-bit sample and coefficients.
*/
`timescale 1ns/1ps
module mce_cal_math
  import mce_pkg::*;
(
  input  wire logic [15:0] sample_fmt,   // Formatted sample
  input  wire logic [15:0] slope,        // Unsigned 8.8 slope
  input  wire logic [15:0] offset,       // Signed offset, result weight
  input  wire logic        temp_mode,    // Offset-only signed path
  input  wire logic [5:0]  temp_offset,  // Signed half-degree offset
  output logic      [15:0] cal_value     // Corrected value
);

  logic        [31:0] prod;
  logic signed [33:0] acc;
  logic signed [33:0] scaled;
  logic signed [17:0] temp_sum;

  always_comb begin
    prod   = sample_fmt * slope;
    acc    = $signed({2'b00, prod}) +
             ($signed({{18{offset[15]}}, offset}) <<< FRAC_BITS) +
             34'sh0_0000_0080;
    scaled = acc >>> FRAC_BITS;
    temp_sum = $signed({{2{sample_fmt[15]}}, sample_fmt}) +
               ($signed({{12{temp_offset[5]}}, temp_offset})
                <<< TEMP_OFFSET_SHIFT);
    if (temp_mode) begin
      if (temp_sum > 18'sh0_7fff) begin
        cal_value = 16'h7fff;
      end else if (temp_sum < -18'sh0_8000) begin
        cal_value = 16'h8000;
      end else begin
        cal_value = temp_sum[15:0];
      end
    end else if (scaled < 0) begin
      cal_value = 16'h0000;
    end else if (scaled > 34'sh0_0000_ffff) begin
      cal_value = 16'hffff;
    end else begin
      cal_value = scaled[15:0];
    end
  end

endmodule

//--- testbench/mce_props.sv
/* Port checker for mce_top.
   Bound from the testbench top file; one clock domain. */
`timescale 1ns/1ps
module mce_props
  import mce_pkg::*;
(
  input wire logic        clk,      // Clock
  input wire logic        reset_n,  // Reset
  input wire logic        mem_wr_en,  // Write
  input wire logic [7:0]  mem_addr,   // Address
  input wire logic [7:0]  mem_wdata,  // Data in
  input wire logic [7:0]  mem_rdata,  // Data out
  input wire logic        sample_valid, // Strobe
  input wire logic [2:0]  sample_chan,  // Channel
  input wire logic [11:0] sample_code,  // Code
  input wire logic [15:0] supply_result_pair,   // Supply
  input wire logic [7:0]  bias_result_high,     // Bias
  input wire logic [7:0]  bias_result_low,      // Bias
  input wire logic [7:0]  tx_power_result_high, // TX
  input wire logic [7:0]  tx_power_result_low,  // TX
  input wire logic [7:0]  rx_power_result_high, // RX
  input wire logic [7:0]  rx_power_result_low,  // RX
  input wire logic        internal_cal_select   // Mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire ext = sample_valid && !internal_cal_select;
  chk_mode_bit: assert property (mem_wr_en && mem_addr == CFG_THREE_ADDR
    |=> internal_cal_select == $past(mem_wdata[0])) else $error("mode bit");
  chk_tx_ext: assert property (ext && sample_chan == CH_TX
    |=> {tx_power_result_high, tx_power_result_low}
        == {$past(sample_code[7:0]), 8'h00}) else $error("tx format");
  chk_bias_ext: assert property (ext && sample_chan == CH_BIAS
    |=> {bias_result_high, bias_result_low}
        == {$past(sample_code[7:0]), 8'h00}) else $error("bias format");
  chk_rx_ext: assert property (ext && sample_chan == CH_RX
    |=> {rx_power_result_high, rx_power_result_low}
        == {$past(sample_code), 4'h0}) else $error("rx format");
  chk_supply_ext: assert property (ext && sample_chan == CH_SUPPLY
    |=> supply_result_pair == {$past(sample_code[7:0]), 8'h00})
    else $error("supply format");
  chk_rdata_echo: assert property ((mem_wr_en ##1
    (!mem_wr_en && mem_addr == $past(mem_addr)))
    |=> mem_rdata == $past(mem_wdata, 2)) else $error("read back");
  chk_tx_hold: assert property (!(sample_valid && sample_chan == CH_TX)
    |=> $stable({tx_power_result_high, tx_power_result_low}))
    else $error("tx changed");
  chk_chan_ignore: assert property (sample_valid && sample_chan > 3'h4
    |=> $stable({supply_result_pair, bias_result_high, rx_power_result_high,
                 rx_power_result_low})) else $error("bad channel used");
  cover property (sample_valid && internal_cal_select && sample_chan == CH_RX);
  cover property (ext && sample_chan == CH_TX);
  cover property (mem_wr_en && mem_addr == CFG_THREE_ADDR);
endmodule

//--- testbench/mce_host_model.sv
/* Host side model: writes and reads configuration bytes.
   Assumes the caller starts each task at a falling edge. */
`timescale 1ns/1ps
module mce_host_model (
  input  wire logic       clk,       // Clock
  input  wire logic [7:0] mem_rdata, // Read data
  output logic            mem_wr_en, // Write strobe
  output logic      [7:0] mem_addr,  // Address
  output logic      [7:0] mem_wdata  // Write data
);
  initial begin
    mem_wr_en = 1'b0;
    mem_addr  = 8'h00;
    mem_wdata = 8'h00;
  end
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    mem_wr_en = 1'b1;
    mem_addr  = a;
    mem_wdata = d;
    @(negedge clk);
    mem_wr_en = 1'b0;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr8(a, d[15:8]);
    wr8(a + 8'h01, d[7:0]);
  endtask
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    mem_addr = a;
    @(negedge clk);
    d = mem_rdata;
  endtask
endmodule

//--- testbench/mce_top_tb.sv
/* Self-checking bench for mce_top.
   Drives inputs at the falling edge; host model holds the byte port. */
`timescale 1ns/1ps
module mce_top_tb;
  logic        clk, reset_n, wen, sv, ics;
  logic [7:0]  ad, wd, rd, bh, bl, th, tl, rh, rl, d;
  logic [2:0]  sc;
  logic [11:0] sk;
  logic [15:0] tp, sp;
  int          n_mismatch, checked;
  mce_top u_mce_top(.clk(clk), .reset_n(reset_n), .mem_wr_en(wen),
    .mem_addr(ad), .mem_wdata(wd), .mem_rdata(rd), .sample_valid(sv),
    .sample_chan(sc), .sample_code(sk), .temperature_result_pair(tp),
    .supply_result_pair(sp), .bias_result_high(bh), .bias_result_low(bl),
    .tx_power_result_high(th), .tx_power_result_low(tl),
    .rx_power_result_high(rh), .rx_power_result_low(rl),
    .internal_cal_select(ics));
  mce_host_model u_mce_host_model(.clk(clk), .mem_rdata(rd),
    .mem_wr_en(wen), .mem_addr(ad), .mem_wdata(wd));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic smp(input logic [2:0] c, input logic [11:0] k);
    @(negedge clk);
    sv = 1'b1;
    sc = c;
    sk = k;
    @(negedge clk);
    sv = 1'b0;
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    sv = 1'b0;
    sc = 3'h0;
    sk = 12'h000;
    repeat (8) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    repeat (3) @(posedge clk);
    chk("mode", 16'h0000, {15'h0000, ics});
    u_mce_host_model.rd8(8'h4a, d);
    chk("toff_reset", 16'h0000, {8'h00, d});
    u_mce_host_model.wr16(8'h4c, 16'h0100);
    u_mce_host_model.rd8(8'h4c, d);
    chk("vslope", 16'h0001, {8'h00, d});
    u_mce_host_model.wr8(8'h4a, 8'hc3);
    u_mce_host_model.rd8(8'h4a, d);
    chk("toff", 16'h00c3, {8'h00, d});
    smp(3'h1, 12'h09c);
    chk("supply", 16'h9c00, sp);
    smp(3'h0, 12'h032);
    chk("temp", 16'h1a80, tp);
    smp(3'h2, 12'h05a);
    chk("bias", 16'h5a00, {bh, bl});
    smp(3'h3, 12'h0a5);
    chk("tx", 16'ha500, {th, tl});
    smp(3'h4, 12'habc);
    chk("rx", 16'habc0, {rh, rl});
    smp(3'h5, 12'hfff);
    smp(3'h7, 12'h000);
    chk("ignored", 16'habc0, {rh, rl});
    chk("ignored_temp", 16'h1a80, tp);
    u_mce_host_model.wr8(8'h03, 8'h01);
    chk("mode", 16'h0001, {15'h0000, ics});
    u_mce_host_model.wr16(8'h4c, 16'h0181);
    u_mce_host_model.wr16(8'h4e, 16'hfffe);
    smp(3'h1, 12'h040);
    chk("supply_int", 16'h603e, sp);
    smp(3'h0, 12'h032);
    chk("temp_int", 16'h1a80, tp);
    u_mce_host_model.wr16(8'h50, 16'h0200);
    u_mce_host_model.wr16(8'h52, 16'h0005);
    smp(3'h2, 12'h010);
    chk("bias_int", 16'h2005, {bh, bl});
    u_mce_host_model.wr16(8'h54, 16'h0080);
    u_mce_host_model.wr16(8'h56, 16'hfff0);
    smp(3'h3, 12'h040);
    chk("tx_int", 16'h1ff0, {th, tl});
    smp(3'h3, 12'h000);
    chk("tx_clamp", 16'h0000, {th, tl});
    u_mce_host_model.wr16(8'h28, 16'h0008);
    smp(3'h4, 12'h001);
    chk("rx_round", 16'h0001, {rh, rl});
    for (int m = 0; m < 8; m++) begin
      u_mce_host_model.wr16(8'h28 + 8'(4 * m), 16'h0100);
      u_mce_host_model.wr16(8'h2a + 8'(4 * m), 16'(m));
    end
    for (int m = 0; m < 8; m++) begin
      smp(3'h4, 12'(512 * m));
      chk("rx_fixed", 16'(8192 * m + m), {rh, rl});
    end
    u_mce_host_model.wr8(8'h06, 8'h20);
    for (int i = 0; i < 7; i++) begin
      u_mce_host_model.wr16(8'hd0 + 8'(2 * i), 16'(4096 * (i + 1)));
    end
    for (int m = 1; m < 8; m++) begin
      smp(3'h4, 12'(256 * m));
      chk("rx_prog", 16'(4096 * m + m), {rh, rl});
      smp(3'h4, 12'(256 * m - 1));
      chk("rx_below", 16'(4096 * m - 17 + m), {rh, rl});
    end
    u_mce_host_model.wr8(8'h06, 8'h60);
    smp(3'h4, 12'h100);
    chk("rx_fixed3", 16'h1000, {rh, rl});
    for (int m = 0; m < 8; m++) begin
      u_mce_host_model.wr16(8'h2a + 8'(4 * m), 16'h0007);
    end
    smp(3'h4, 12'h100);
    chk("rx_static_lo", 16'h1007, {rh, rl});
    smp(3'h4, 12'hf00);
    chk("rx_static_hi", 16'hf007, {rh, rl});
    print_verdict();
  end
endmodule
bind mce_top mce_props u_mce_props(.clk(clk), .reset_n(reset_n),
  .mem_wr_en(mem_wr_en), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .sample_valid(sample_valid),
  .sample_chan(sample_chan), .sample_code(sample_code),
  .supply_result_pair(supply_result_pair),
  .bias_result_high(bias_result_high), .bias_result_low(bias_result_low),
  .tx_power_result_high(tx_power_result_high),
  .tx_power_result_low(tx_power_result_low),
  .rx_power_result_high(rx_power_result_high),
  .rx_power_result_low(rx_power_result_low),
  .internal_cal_select(internal_cal_select));
